// ==== hw/ascif_core.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ascif_defines.vh"

// Contract
// - Result shifts out while command shifts in
// - DSP: MSB at frame fall, rest on rises
// - DSP command capture edge follows invert input
// - DSP: rise after frame rise restarts counters
// - DSP: fall while frame high resets state
// - DSP: sixteen clocks, six trailing zeros
// - Chip select edges initialise, reset, disable
// - Processor: sample at rise four, convert ten
// - Processor: MSB at select fall, rest falls
// - Processor command capture edge follows invert
// - Command MSB first into four-bit register
// - Codes zero to seven pick channels
// - Code eight powers down until next access
// - Rate codes and reserved give no result
// - Self-test codes give fixed results
// - Normal sampling lasts six clock periods in DSP framing, six and a half in processor framing
// - Processor: hold sample at tenth fall
// - Framing mode latched at select fall
// - DSP: tenth fall hands over conversion
// - End-of-conversion low at tenth rise
module ascif_core
(
	input  wire                    sys_clk,
	input  wire                    arst_n,
	input  wire                    clk_en,
	input  wire                    cs_n_pin,
	input  wire                    frame_sync_in,
	input  wire                    shift_clk_pin,
	input  wire                    serial_data_in,
	input  wire                    shift_edge_invert,
	input  wire                    sample_start_n,
	output wire                    serial_data_out,
	output wire                    serial_data_out_oe,
	output wire                    eoc_out,
	output wire                    sampling_out,
	output wire                    proc_mode_out,
	output wire                    power_down_out,
	output wire                    fast_rate_out,
	output wire [2:0]              conv_channel,
	output wire                    conv_start,
	input  wire                    res_valid,
	output wire                    res_ready,
	input  wire [`ASCIF_RES_W-1:0] res_data
);

	localparam CV_IDLE = 1'b0;
	localparam CV_WAIT = 1'b1;

	wire [`ASCIF_PIN_W-1:0] pin_s;

	ascif_sync #(
		.WIDTH (`ASCIF_PIN_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.clk_en   (clk_en),
		.async_in ({cs_n_pin, frame_sync_in, shift_clk_pin,
			serial_data_in, shift_edge_invert, sample_start_n}),
		.sync_out (pin_s)
	);

	wire cs_s    = pin_s[`ASCIF_PIN_CS];
	wire fs_s    = pin_s[`ASCIF_PIN_FS];
	wire sck_s   = pin_s[`ASCIF_PIN_SCK];
	wire din_s   = pin_s[`ASCIF_PIN_DIN];
	wire inv_s   = pin_s[`ASCIF_PIN_INV];
	wire start_s = pin_s[`ASCIF_PIN_START];

	reg                      cs_d_reg;
	reg                      fs_d_reg;
	reg                      sck_d_reg;
	reg                      proc_mode_reg;
	reg                      io_en_reg;
	reg                      frame_reg;
	reg                      armed_reg;
	reg [`ASCIF_CNT_W-1:0]   rise_cnt_reg;
	reg [`ASCIF_CNT_W-1:0]   fall_cnt_reg;
	reg [3:0]                cmd_shift_reg;
	reg [2:0]                cmd_cnt_reg;
	reg [3:0]                cmd_reg;
	reg                      cmd_ok_reg;
	reg [`ASCIF_FRAME_W-1:0] out_shift_reg;
	reg [`ASCIF_RES_W-1:0]   result_reg;
	reg                      eoc_reg;
	reg                      sampling_reg;
	reg                      pdown_reg;
	reg                      fast_reg;
	reg [2:0]                channel_reg;
	reg                      conv_start_reg;
	reg                      state_reg;
	reg                      state_next;
	reg                      test_push;
	reg [`ASCIF_RES_W-1:0]   test_value;

	wire cs_fall  = cs_d_reg & ~cs_s;
	wire cs_rise  = ~cs_d_reg & cs_s;
	wire fs_fall  = fs_d_reg & ~fs_s;
	wire fs_rise  = ~fs_d_reg & fs_s;
	wire sck_rise = ~sck_d_reg & sck_s;
	wire sck_fall = sck_d_reg & ~sck_s;

	// A transfer is live while select is low; in DSP framing it also needs the frame.
	wire live     = io_en_reg & (proc_mode_reg | frame_reg);
	wire dsp_rst  = io_en_reg & ~proc_mode_reg & fs_s & sck_fall;
	wire cnt_rise = live & sck_rise;
	wire cnt_fall = live & sck_fall;

	wire [`ASCIF_CNT_W-1:0] rise_n = (rise_cnt_reg == `ASCIF_CNT_MAX) ?
		rise_cnt_reg : rise_cnt_reg + `ASCIF_CNT_ONE;
	wire [`ASCIF_CNT_W-1:0] fall_n = (fall_cnt_reg == `ASCIF_CNT_MAX) ?
		fall_cnt_reg : fall_cnt_reg + `ASCIF_CNT_ONE;

	// Capture edge: processor uses rise when inverted-high, DSP the opposite.
	wire cap_on_rise = proc_mode_reg ? inv_s : ~inv_s;
	wire cap_edge    = cap_on_rise ? cnt_rise : cnt_fall;
	wire cap_take    = cap_edge & (cmd_cnt_reg != `ASCIF_CMD_W);
	wire [3:0] cmd_n = {cmd_shift_reg[2:0], din_s};
	wire cmd_done    = cap_take & (cmd_cnt_reg == `ASCIF_CMD_W - 3'h1);

	// Output advances on falls in processor framing, rises in DSP framing.
	wire out_edge = proc_mode_reg ? cnt_fall : cnt_rise;

	wire rise4  = cnt_rise & (rise_n == `ASCIF_EDGE_SAMPLE);
	wire rise10 = cnt_rise & (rise_n == `ASCIF_EDGE_CONVERT);
	wire fall4  = cnt_fall & (fall_n == `ASCIF_EDGE_SAMPLE);
	wire fall10 = cnt_fall & (fall_n == `ASCIF_EDGE_CONVERT);

	wire samp_begin = start_s & (proc_mode_reg ? rise4 : fall4);
	wire samp_end   = fall10;
	wire conv_edge  = proc_mode_reg ? rise10 : fall10;

	// Only channel and self-test codes produce a conversion result.
	wire is_channel = ~cmd_reg[`ASCIF_CMD_CH_MSB];
	wire is_test    = (cmd_reg == `ASCIF_CMD_TEST_MID) |
		(cmd_reg == `ASCIF_CMD_TEST_LOW) | (cmd_reg == `ASCIF_CMD_TEST_HIGH);
	wire gives_res  = cmd_ok_reg & (is_channel | is_test);
	wire conv_go    = conv_edge & start_s & gives_res & (state_reg == CV_IDLE);
	// In DSP framing the conversion is already awaited when the tenth rise arrives.
	wire eoc_drop   = rise10 & (conv_go | (state_reg == CV_WAIT));

	wire                    fifo_in_valid;
	wire                    fifo_in_ready;
	wire [`ASCIF_RES_W-1:0] fifo_in_data;
	wire                    fifo_out_valid;
	wire                    fifo_out_ready;
	wire [`ASCIF_RES_W-1:0] fifo_out_data;

	assign fifo_in_valid  = test_push | res_valid;
	assign fifo_in_data   = test_push ? test_value : res_data;
	assign res_ready      = fifo_in_ready & ~test_push;
	assign fifo_out_ready = (state_reg == CV_WAIT);

	ascif_fifo #(
		.WIDTH (`ASCIF_RES_W),
		.DEPTH (`ASCIF_FIFO_DEPTH),
		.AW    (`ASCIF_FIFO_AW)
	) u_fifo (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	wire res_pop = fifo_out_valid & fifo_out_ready;

	always @*
	begin
		test_push  = 1'b0;
		test_value = `ASCIF_RES_MID;
		state_next = state_reg;
		case (cmd_reg)
			`ASCIF_CMD_TEST_LOW:  test_value = `ASCIF_RES_LOW;
			`ASCIF_CMD_TEST_HIGH: test_value = `ASCIF_RES_HIGH;
			default:              test_value = `ASCIF_RES_MID;
		endcase
		case (state_reg)
			CV_IDLE:
			begin
				if (conv_go)
				begin
					test_push  = is_test;
					state_next = CV_WAIT;
				end
			end
			CV_WAIT:
			begin
				if (res_pop)
					state_next = CV_IDLE;
			end
			default:
				state_next = CV_IDLE;
		endcase
	end

	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_d_reg       <= 1'b1;
			fs_d_reg       <= 1'b1;
			sck_d_reg      <= 1'b1;
			proc_mode_reg  <= 1'b1;
			io_en_reg      <= 1'b0;
			frame_reg      <= 1'b0;
			armed_reg      <= 1'b0;
			rise_cnt_reg   <= `ASCIF_CNT_ZERO;
			fall_cnt_reg   <= `ASCIF_CNT_ZERO;
			cmd_shift_reg  <= 4'h0;
			cmd_cnt_reg    <= 3'h0;
			cmd_reg        <= 4'h0;
			cmd_ok_reg     <= 1'b0;
			out_shift_reg  <= {`ASCIF_FRAME_W{1'b0}};
			result_reg     <= {`ASCIF_RES_W{1'b0}};
			eoc_reg        <= 1'b1;
			sampling_reg   <= 1'b0;
			pdown_reg      <= 1'b0;
			fast_reg       <= 1'b1;
			channel_reg    <= 3'h0;
			conv_start_reg <= 1'b0;
			state_reg      <= CV_IDLE;
		end
		else if (clk_en)
		begin
			cs_d_reg       <= cs_s;
			fs_d_reg       <= fs_s;
			sck_d_reg      <= sck_s;
			state_reg      <= state_next;
			conv_start_reg <= conv_go & ~is_test;

			if (cs_fall)
			begin
				proc_mode_reg <= fs_s;
				io_en_reg     <= 1'b1;
				frame_reg     <= 1'b0;
				armed_reg     <= 1'b0;
				rise_cnt_reg  <= `ASCIF_CNT_ZERO;
				fall_cnt_reg  <= `ASCIF_CNT_ZERO;
				cmd_cnt_reg   <= 3'h0;
				cmd_ok_reg    <= 1'b0;
				sampling_reg  <= 1'b0;
				out_shift_reg <= {result_reg, {(`ASCIF_FRAME_W-`ASCIF_RES_W){1'b0}}};
				pdown_reg     <= 1'b0;
			end
			else if (cs_rise)
			begin
				io_en_reg <= 1'b0;
				frame_reg <= 1'b0;
				armed_reg <= 1'b0;
				if (proc_mode_reg)
				begin
					rise_cnt_reg <= `ASCIF_CNT_ZERO;
					fall_cnt_reg <= `ASCIF_CNT_ZERO;
					cmd_cnt_reg  <= 3'h0;
					sampling_reg <= 1'b0;
				end
			end
			else if (dsp_rst)
			begin
				frame_reg    <= 1'b0;
				armed_reg    <= 1'b1;
				cmd_cnt_reg  <= 3'h0;
				sampling_reg <= 1'b0;
			end
			else
			begin
				if (io_en_reg && !proc_mode_reg && fs_rise)
					armed_reg <= 1'b1;
				if (io_en_reg && !proc_mode_reg && armed_reg && sck_rise)
				begin
					armed_reg    <= 1'b0;
					rise_cnt_reg <= `ASCIF_CNT_ZERO;
					fall_cnt_reg <= `ASCIF_CNT_ZERO;
					cmd_cnt_reg  <= 3'h0;
				end
				if (io_en_reg && !proc_mode_reg && fs_fall)
				begin
					frame_reg     <= 1'b1;
					rise_cnt_reg  <= `ASCIF_CNT_ZERO;
					fall_cnt_reg  <= `ASCIF_CNT_ZERO;
					cmd_cnt_reg   <= 3'h0;
					cmd_ok_reg    <= 1'b0;
					out_shift_reg <= {result_reg, {(`ASCIF_FRAME_W-`ASCIF_RES_W){1'b0}}};
				end
				if (cnt_rise)
					rise_cnt_reg <= rise_n;
				if (cnt_fall)
					fall_cnt_reg <= fall_n;
				if (cap_take)
				begin
					cmd_shift_reg <= cmd_n;
					cmd_cnt_reg   <= cmd_cnt_reg + 3'h1;
				end
				if (cmd_done)
				begin
					cmd_reg    <= cmd_n;
					cmd_ok_reg <= 1'b1;
					if (!cmd_n[`ASCIF_CMD_CH_MSB])
						channel_reg <= cmd_n[2:0];
					if (cmd_n == `ASCIF_CMD_PDOWN)
						pdown_reg <= 1'b1;
					if (cmd_n == `ASCIF_CMD_FAST)
						fast_reg <= 1'b1;
					if (cmd_n == `ASCIF_CMD_SLOW)
						fast_reg <= 1'b0;
				end
				// Zero fill after the result gives the trailing zeros.
				if (out_edge)
					out_shift_reg <= {out_shift_reg[`ASCIF_FRAME_W-2:0], 1'b0};
				if (samp_begin)
					sampling_reg <= 1'b1;
				else if (samp_end)
					sampling_reg <= 1'b0;
			end

			// A result that lands on the tenth rise must not leave the flag low.
			if (res_pop)
				eoc_reg <= 1'b1;
			else if (eoc_drop)
				eoc_reg <= 1'b0;
			if (res_pop)
				result_reg <= fifo_out_data;
		end
	end

	assign serial_data_out    = out_shift_reg[`ASCIF_FRAME_W-1];
	assign serial_data_out_oe = io_en_reg;
	assign eoc_out            = eoc_reg;
	assign sampling_out       = sampling_reg;
	assign proc_mode_out      = proc_mode_reg;
	assign power_down_out     = pdown_reg;
	assign fast_rate_out      = fast_reg;
	assign conv_channel       = channel_reg;
	assign conv_start         = conv_start_reg;

endmodule // ascif_core

`default_nettype wire

// ==== hw/ascif_defines.vh ====
`ifndef ASCIF_DEFINES_VH
`define ASCIF_DEFINES_VH

// Serial command and result framing.
`define ASCIF_CMD_W         3'h4
`define ASCIF_RES_W         10
`define ASCIF_FRAME_W       16
`define ASCIF_CNT_W         5
`define ASCIF_CNT_ZERO      5'h00
`define ASCIF_CNT_ONE       5'h01
`define ASCIF_CNT_MAX       5'h1F
`define ASCIF_EDGE_SAMPLE   5'h04
`define ASCIF_EDGE_CONVERT  5'h0A

// Command codes.
`define ASCIF_CMD_CH_MSB    3
`define ASCIF_CMD_PDOWN     4'h8
`define ASCIF_CMD_FAST      4'h9
`define ASCIF_CMD_SLOW      4'hA
`define ASCIF_CMD_TEST_MID  4'hB
`define ASCIF_CMD_TEST_LOW  4'hC
`define ASCIF_CMD_TEST_HIGH 4'hD

// Fixed self-test results.
`define ASCIF_RES_MID       10'h200
`define ASCIF_RES_LOW       10'h000
`define ASCIF_RES_HIGH      10'h3FF

// Result buffer.
`define ASCIF_FIFO_DEPTH    32
`define ASCIF_FIFO_AW       5

// Synchronised pin bundle positions.
`define ASCIF_PIN_W         6
`define ASCIF_PIN_CS        5
`define ASCIF_PIN_FS        4
`define ASCIF_PIN_SCK       3
`define ASCIF_PIN_DIN       2
`define ASCIF_PIN_INV       1
`define ASCIF_PIN_START     0

`endif

// ==== hw/ascif_sync.v ====
`timescale 1ns/100ps
`default_nettype none

module ascif_sync
#(
	parameter WIDTH = 1
)
(
	input  wire             sys_clk,
	input  wire             arst_n,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end
		else if (clk_en)
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule // ascif_sync

`default_nettype wire

// ==== hw/ascif_fifo.v ====
`timescale 1ns/100ps
`default_nettype none

module ascif_fifo
#(
	parameter WIDTH = 10,
	parameter DEPTH = 32,
	parameter AW    = 5
)
(
	input  wire             sys_clk,
	input  wire             arst_n,
	input  wire             clk_en,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg [WIDTH-1:0] out_data_reg;
	reg             out_valid_reg;

	wire push = in_valid & in_ready;
	wire load = (count_reg != {(AW+1){1'b0}}) & (~out_valid_reg | out_ready);
	// The output register is one of the DEPTH words, so it counts towards full.
	wire [AW:0] held = count_reg + {{AW{1'b0}}, out_valid_reg};

	assign in_ready  = (held != DEPTH[AW:0]);
	assign out_valid = out_valid_reg;
	assign out_data  = out_data_reg;

	always @(posedge sys_clk)
	begin
		if (clk_en && push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr_reg    <= {AW{1'b0}};
			rd_ptr_reg    <= {AW{1'b0}};
			count_reg     <= {(AW+1){1'b0}};
			out_data_reg  <= {WIDTH{1'b0}};
			out_valid_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (load)
			begin
				rd_ptr_reg   <= rd_ptr_reg + 1'b1;
				out_data_reg <= mem[rd_ptr_reg];
			end
			if (load)
				out_valid_reg <= 1'b1;
			else if (out_ready)
				out_valid_reg <= 1'b0;
			if (push && !load)
				count_reg <= count_reg + 1'b1;
			else if (!push && load)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule // ascif_fifo

`default_nettype wire

// ==== verification/ascif_core_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module ascif_core_chk
(
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       clk_en,
	input wire logic       cs_n_pin,
	input wire logic       frame_sync_in,
	input wire logic       shift_clk_pin,
	input wire logic       serial_data_in,
	input wire logic       shift_edge_invert,
	input wire logic       sample_start_n,
	input wire logic       serial_data_out,
	input wire logic       serial_data_out_oe,
	input wire logic       eoc_out,
	input wire logic       sampling_out,
	input wire logic       proc_mode_out,
	input wire logic       power_down_out,
	input wire logic       fast_rate_out,
	input wire logic [2:0] conv_channel,
	input wire logic       conv_start,
	input wire logic       res_valid,
	input wire logic       res_ready,
	input wire logic [9:0] res_data
);
	logic [7:0] samp_cnt_reg;

	// Length of the current sampling window in system clocks.
	always @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			samp_cnt_reg <= 8'h00;
		else if (sampling_out)
			samp_cnt_reg <= samp_cnt_reg + 8'h01;
		else
			samp_cnt_reg <= 8'h00;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	oe_released_a: assert property (cs_n_pin [*6] |-> !serial_data_out_oe)
		else $error("output enable kept while deselected");
	oe_driven_a: assert property ((!cs_n_pin) [*6] |-> serial_data_out_oe)
		else $error("output not driven while selected");
	mode_latch_a: assert property ($fell(cs_n_pin) |-> ##6 (proc_mode_out == $past(frame_sync_in, 6)))
		else $error("framing mode not taken from frame sync");
	pd_clear_a: assert property ($fell(cs_n_pin) |-> ##[2:6] !power_down_out)
		else $error("power down not cleared by access");
	conv_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("conversion request longer than one cycle");
	conv_eoc_a: assert property (conv_start && proc_mode_out |-> !eoc_out)
		else $error("conversion requested with end flag high");
	eoc_select_a: assert property ($fell(eoc_out) |-> !cs_n_pin && serial_data_out_oe)
		else $error("end flag fell outside a transfer");
	samp_len_a: assert property ($fell(sampling_out) |-> samp_cnt_reg >= 8'h28 && samp_cnt_reg <= 8'h34)
		else $error("sampling window of wrong length");
	data_zero_a: assert property ($fell(sampling_out) && proc_mode_out |-> !serial_data_out)
		else $error("output not zero when sample held");

	cover property ($fell(eoc_out));
	cover property (conv_start && !proc_mode_out);
	cover property ($rose(power_down_out));
	cover property (!res_ready);
endmodule // ascif_core_chk

bind ascif_core ascif_core_chk i_ascif_core_chk (.sys_clk, .arst_n, .clk_en, .cs_n_pin,
	.frame_sync_in, .shift_clk_pin, .serial_data_in, .shift_edge_invert, .sample_start_n,
	.serial_data_out, .serial_data_out_oe, .eoc_out, .sampling_out, .proc_mode_out,
	.power_down_out, .fast_rate_out, .conv_channel, .conv_start, .res_valid, .res_ready,
	.res_data);
`default_nettype wire

// ==== verification/ascif_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ascif_host_model
(
	input  wire logic sys_clk,
	input  wire logic serial_data_out,
	output var  logic cs_n_pin,
	output var  logic frame_sync_in,
	output var  logic shift_clk_pin,
	output var  logic serial_data_in
);
	initial
	begin
		cs_n_pin = 1'b1;
		frame_sync_in = 1'b1;
		shift_clk_pin = 1'b0;
		serial_data_in = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// One 16-clock transfer; data in changes one cycle after the second edge of each clock.
	task automatic xfer(input logic dsp, input logic [3:0] cmd, output logic [15:0] got);
		int i;
		frame_sync_in = !dsp;
		serial_data_in = cmd[3];
		cyc(4);
		cs_n_pin = 1'b0;
		cyc(8);
		if (dsp)
		begin
			frame_sync_in = 1'b1;
			cyc(4);
			shift_clk_pin = 1'b1;
			cyc(4);
			shift_clk_pin = 1'b0;
			cyc(4);
			shift_clk_pin = 1'b1;
			cyc(4);
			frame_sync_in = 1'b0;
		end
		for (i = 0; i < 16; i++)
		begin
			cyc(1);
			serial_data_in = (i < 4) ? cmd[3 - i] : !serial_data_in;
			cyc(3);
			shift_clk_pin = !shift_clk_pin;
			cyc(2);
			got[15 - i] = serial_data_out;
			cyc(2);
			if (i < 15 || !dsp)
				shift_clk_pin = !shift_clk_pin;
		end
		cyc(4);
		cs_n_pin = 1'b1;
		frame_sync_in = 1'b1;
		serial_data_in = !serial_data_in;
		cyc(40);
	endtask
endmodule // ascif_host_model
`default_nettype wire

// ==== verification/ascif_core_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module ascif_core_tb;
	logic        sys_clk, arst_n, clk_en, shift_edge_invert, sample_start_n, res_valid;
	logic        cs_n_pin, frame_sync_in, shift_clk_pin, serial_data_in, serial_data_out;
	logic        serial_data_out_oe, eoc_out, sampling_out, proc_mode_out, power_down_out;
	logic        fast_rate_out, conv_start, res_ready, conv_en;
	logic [2:0]  conv_channel;
	logic [9:0]  res_data;
	logic [15:0] got, prev;
	int          errors, n_compared, k;

	ascif_core i_ascif_core (.sys_clk, .arst_n, .clk_en, .cs_n_pin, .frame_sync_in,
		.shift_clk_pin, .serial_data_in, .shift_edge_invert, .sample_start_n,
		.serial_data_out, .serial_data_out_oe, .eoc_out, .sampling_out, .proc_mode_out,
		.power_down_out, .fast_rate_out, .conv_channel, .conv_start, .res_valid,
		.res_ready, .res_data);
	ascif_host_model i_ascif_host_model (.sys_clk, .serial_data_out, .cs_n_pin,
		.frame_sync_in, .shift_clk_pin, .serial_data_in);

	always #12.5 sys_clk = !sys_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic push(input logic [9:0] d);
		@(negedge sys_clk);
		res_data = d;
		res_valid = 1'b1;
		while (res_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		res_valid = 1'b0;
		res_data = ~d;
	endtask

	task automatic xfer(input logic dsp, input logic [3:0] cmd);
		i_ascif_host_model.xfer(dsp, cmd, got);
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Converter stand-in: answers each request with a channel-tagged word.
	initial
		forever
		begin
			@(posedge conv_start);
			if (conv_en)
			begin
				repeat (10) @(negedge sys_clk);
				push({conv_channel, 7'h55});
			end
		end

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		tally_and_finish;
	end

	initial
	begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		clk_en = 1'b1;
		shift_edge_invert = 1'b1;
		sample_start_n = 1'b1;
		res_valid = 1'b0;
		res_data = 10'h000;
		conv_en = 1'b1;
		errors = 0;
		n_compared = 0;
		repeat (10) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		xfer(1'b0, 4'hB);
		xfer(1'b0, 4'hC);
		chk(got, 16'h8000);
		xfer(1'b1, 4'hD);
		chk(got, 16'h0000);
		prev = 16'hFFC0;
		for (k = 0; k < 8; k++)
		begin
			shift_edge_invert = k[1];
			xfer(k[0], k[3:0]);
			chk(got, prev);
			chk({13'h0000, conv_channel}, {13'h0000, k[2:0]});
			chk({15'h0000, eoc_out}, 16'h0001);
			prev = {k[2:0], 7'h55, 6'h00};
		end
		xfer(1'b0, 4'h9);
		chk(got, prev);
		chk({15'h0000, fast_rate_out}, 16'h0001);
		xfer(1'b1, 4'hA);
		chk({15'h0000, fast_rate_out}, 16'h0000);
		chk({13'h0000, conv_channel}, 16'h0007);
		xfer(1'b0, 4'h8);
		chk({15'h0000, power_down_out}, 16'h0001);
		xfer(1'b1, 4'hE);
		chk({15'h0000, power_down_out}, 16'h0000);
		xfer(1'b0, 4'hF);
		chk(got, prev);
		sample_start_n = 1'b0;
		xfer(1'b1, 4'h2);
		chk({15'h0000, eoc_out}, 16'h0001);
		chk({13'h0000, conv_channel}, 16'h0002);
		sample_start_n = 1'b1;
		xfer(1'b0, 4'hE);
		chk(got, prev);
		conv_en = 1'b0;
		for (k = 0; k < 32; k++)
			push(10'h040 + k[9:0]);
		@(negedge sys_clk);
		chk({15'h0000, res_ready}, 16'h0000);
		xfer(1'b0, 4'h1);
		chk(got, prev);
		for (k = 0; k < 32; k++)
		begin
			xfer(k[0], 4'h1);
			chk(got, {10'h040 + k[9:0], 6'h00});
		end
		chk({15'h0000, res_ready}, 16'h0001);
		tally_and_finish;
	end
endmodule // ascif_core_tb
`default_nettype wire
